// ### core/rps_pkg.sv
// What this block does
// - master clear, software and watchdog resets merge into one system reset.
// - hold reset about 200 us after the supply passes 1.5 V.
// - combined reset is active low and stays low through the delay.
// - after the delay, release reset high and start the power-up time-out.
// - power-up time-out after reset lasts 36 low-speed oscillator cycles.
// - run only after the time-out ends and the supply has reached 3.3 V.
// - analog regulator is switched off whenever deep sleep is entered.
// - core regulator stays enabled in every mode, deep sleep included.
// - deep sleep ends on wake interrupt, host start condition or master clear.
package rps_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS  = 100;
  localparam int RST_DELAY_US   = 200;
  // least time: round up to whole clock cycles
  localparam int RST_DELAY_CYC  =
    (RST_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W          = 12;
  localparam logic [TMR_W-1:0] DELAY_LIMIT  = RST_DELAY_CYC[TMR_W-1:0];
  localparam logic [TMR_W-1:0] PWRT_RESET   = 12'h024; // 36 lso cycles
  localparam logic [TMR_W-1:0] PWRT_SLEEP   = 12'h00A; // 10 lso cycles

  ////////////////////////////////////////////////////////////////////////////
  // sequencer states
  typedef enum logic [4:0] {
    ST_OFF     = 5'h01,
    ST_DELAY   = 5'h02,
    ST_TIMEOUT = 5'h04,
    ST_RUN     = 5'h08,
    ST_SLEEP   = 5'h10
  } rps_state_t;

endpackage

// ### core/rps_timer.sv
`timescale 1ns/1ps
module rps_timer
  import rps_pkg::*;
#(
  parameter int W = TMR_W
)(
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  input  wire logic         clear_i,
  input  wire logic         step_i,
  input  wire logic [W-1:0] limit_i,
  output logic      [W-1:0] count_o,
  output logic              done_o
);

  logic [W-1:0] count;
  logic [W-1:0] next_count;

  ////////////////////////////////////////////////////////////////////////////
  // done fires on the step that completes the interval; it leaves clear out,
  // because the owner builds clear from done and would close a loop
  assign done_o  = step_i && (count == limit_i - 1'b1);
  assign count_o = count;

  // clear has priority so a restart never leaks an old count
  always_comb
  begin
    next_count = count;
    if (clear_i)
      next_count = '0;
    else if (step_i)
      next_count = done_o ? '0 : count + 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      count <= '0;
    else
      count <= next_count;
  end

endmodule // rps_timer

// ### core/rps_supervisor.sv
`timescale 1ns/1ps
module rps_supervisor
  import rps_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic master_clear_pin_n_i,
  input  wire logic software_reset_request_i,
  input  wire logic watchdog_reset_request_i,
  input  wire logic supply_above_1v5_i,
  input  wire logic supply_above_3v3_i,
  input  wire logic low_speed_osc_clock_i,
  input  wire logic deep_sleep_request_i,
  input  wire logic host_wake_interrupt_i,
  input  wire logic host_start_detect_i,
  output logic      combined_reset_n_o,
  output logic      system_start_o,
  output logic      powerup_timeout_o,
  output logic      deep_sleep_o,
  output logic      analog_regulator_en_o,
  output logic      core_regulator_en_o
);

  rps_state_t       state;
  rps_state_t       next_state;
  logic             release_q;
  logic             next_release;
  logic             from_sleep;
  logic             next_from_sleep;
  logic             elapsed;
  logic             next_elapsed;
  logic             lso_q;
  logic             lso_rise;
  logic             any_src;
  logic             tmr_clear;
  logic             tmr_step;
  logic [TMR_W-1:0] tmr_limit;
  logic             tmr_done;
  logic             analog_en;
  logic             next_analog_en;

  ////////////////////////////////////////////////////////////////////////////
  // reset sources; watchdog is off in deep sleep so it is ignored there
  assign any_src = !master_clear_pin_n_i
                 || software_reset_request_i
                 || (watchdog_reset_request_i && state != ST_SLEEP);

  // assertion is combinational, only the release is clocked
  assign combined_reset_n_o = release_q && !any_src;

  // lso is synchronous to clk_i, so a plain edge detect is enough
  assign lso_rise = low_speed_osc_clock_i && !lso_q;

  ////////////////////////////////////////////////////////////////////////////
  // clear reads next_state, so it stays apart from the step decode that
  // feeds done; mixing them would loop through the sequencer
  assign tmr_clear = (state != next_state) || any_src;

  // shared interval timer: clk cycles in delay, lso edges in time-out
  always_comb
  begin
    tmr_step  = 1'b0;
    tmr_limit = DELAY_LIMIT;
    case (state)
      ST_DELAY:   tmr_step = 1'b1;
      ST_TIMEOUT:
      begin
        tmr_step  = lso_rise && !elapsed;
        tmr_limit = from_sleep ? PWRT_SLEEP : PWRT_RESET;
      end
      default:    tmr_step = 1'b0;
    endcase
  end

  rps_timer #(
    .W       (TMR_W)
  ) rps_timer_i (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .clear_i (tmr_clear),
    .step_i  (tmr_step),
    .limit_i (tmr_limit),
    .count_o (),
    .done_o  (tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer next state
  always_comb
  begin
    next_state      = state;
    next_release    = release_q;
    next_from_sleep = from_sleep;
    next_elapsed    = elapsed;
    case (state)
      ST_OFF:
        if (supply_above_1v5_i)
          next_state = ST_DELAY;
      ST_DELAY:
        if (tmr_done && !any_src)
        begin
          next_state      = ST_TIMEOUT;
          next_release    = 1'b1;
          next_from_sleep = 1'b0;
          next_elapsed    = 1'b0;
        end
      ST_TIMEOUT:
      begin
        if (tmr_done)
          next_elapsed = 1'b1;
        // a slow supply keeps the core waiting past the time-out
        if ((elapsed || tmr_done) && supply_above_3v3_i)
          next_state = ST_RUN;
      end
      ST_RUN:
        if (deep_sleep_request_i)
          next_state = ST_SLEEP;
      ST_SLEEP:
        if (host_wake_interrupt_i || host_start_detect_i)
        begin
          next_state      = ST_TIMEOUT;
          next_from_sleep = 1'b1;
          next_elapsed    = 1'b0;
        end
      default:
        next_state = ST_OFF;
    endcase
    // any reasserted source except the watchdog in deep sleep restarts the whole delay, master clear wakes too
    if (any_src && state != ST_OFF)
    begin
      next_state   = ST_DELAY;
      next_release = 1'b0;
    end
    if (!supply_above_1v5_i)
    begin
      next_state   = ST_OFF;
      next_release = 1'b0;
    end
    next_analog_en = (next_state != ST_SLEEP);
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state      <= ST_OFF;
      release_q  <= 1'b0;
      from_sleep <= 1'b0;
      elapsed    <= 1'b0;
      lso_q      <= 1'b0;
      analog_en  <= 1'b1;
    end
    else
    begin
      state      <= next_state;
      release_q  <= next_release;
      from_sleep <= next_from_sleep;
      elapsed    <= next_elapsed;
      lso_q      <= low_speed_osc_clock_i;
      analog_en  <= next_analog_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs; core regulator never drops so state survives deep sleep
  assign system_start_o        = (state == ST_RUN);
  assign powerup_timeout_o     = (state == ST_TIMEOUT);
  assign deep_sleep_o          = (state == ST_SLEEP);
  assign analog_regulator_en_o = analog_en;
  assign core_regulator_en_o   = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // checking helpers: independent cycle and lso edge counts
  logic [TMR_W-1:0] chk_dly;
  logic [TMR_W-1:0] chk_lso;

  always_ff @(posedge clk_i)
  begin
    if (srst_i || state != ST_DELAY || any_src)
      chk_dly <= '0;
    else
      chk_dly <= chk_dly + 1'b1;
    if (srst_i || state != ST_TIMEOUT || any_src)
      chk_lso <= '0;
    else if (lso_rise && chk_lso != 12'hFFF)
      chk_lso <= chk_lso + 1'b1;
  end

  sequence s_delay_end;
    state == ST_DELAY ##1 state == ST_TIMEOUT;
  endsequence

  sequence s_sleep_wake;
    state == ST_SLEEP && (host_wake_interrupt_i || host_start_detect_i)
      && supply_above_1v5_i;
  endsequence

  property p_merge;
    @(posedge clk_i) disable iff (srst_i)
      any_src |-> !combined_reset_n_o;
  endproperty
  a_merge: assert property (p_merge)
    else $error("reset source did not pull combined reset low");

  property p_delay_len;
    @(posedge clk_i) disable iff (srst_i)
      (state == ST_DELAY && next_state == ST_TIMEOUT)
        |-> chk_dly == DELAY_LIMIT - 1'b1;
  endproperty
  a_delay_len: assert property (p_delay_len)
    else $error("supply reset delay has wrong length");

  property p_low_in_delay;
    @(posedge clk_i) disable iff (srst_i)
      (state == ST_DELAY || state == ST_OFF) |-> !combined_reset_n_o;
  endproperty
  a_low_in_delay: assert property (p_low_in_delay)
    else $error("combined reset high during reset delay");

  property p_release;
    @(posedge clk_i) disable iff (srst_i)
      s_delay_end |-> (any_src || combined_reset_n_o) && powerup_timeout_o;
  endproperty
  a_release: assert property (p_release)
    else $error("reset not released when time-out began");

  property p_pwrt_len;
    @(posedge clk_i) disable iff (srst_i)
      (state == ST_TIMEOUT && next_state == ST_RUN && !from_sleep)
        |-> chk_lso + {11'h000, lso_rise} >= PWRT_RESET;
  endproperty
  a_pwrt_len: assert property (p_pwrt_len)
    else $error("power-up time-out shorter than 36 lso cycles");

  property p_start;
    @(posedge clk_i) disable iff (srst_i)
      $rose(system_start_o) |-> $past(supply_above_3v3_i)
        && $past(state == ST_TIMEOUT);
  endproperty
  a_start: assert property (p_start)
    else $error("started without time-out or 3.3 V supply");

  property p_analog_off;
    @(posedge clk_i) disable iff (srst_i)
      deep_sleep_o |-> !analog_regulator_en_o;
  endproperty
  a_analog_off: assert property (p_analog_off)
    else $error("analog regulator on in deep sleep");

  property p_core_on;
    @(posedge clk_i) disable iff (srst_i)
      deep_sleep_o |-> core_regulator_en_o ##1 core_regulator_en_o;
  endproperty
  a_core_on: assert property (p_core_on)
    else $error("core regulator dropped");

  property p_wake;
    @(posedge clk_i) disable iff (srst_i)
      s_sleep_wake |=> !deep_sleep_o && analog_regulator_en_o;
  endproperty
  a_wake: assert property (p_wake)
    else $error("deep sleep not left on wake event");

  property p_restart;
    @(posedge clk_i) disable iff (srst_i)
      (any_src && supply_above_1v5_i && state != ST_OFF)
        |=> state == ST_DELAY && chk_dly == '0;
  endproperty
  a_restart: assert property (p_restart)
    else $error("reset source did not restart the delay");

endmodule // rps_supervisor

// ### bench/rps_board.sv
`timescale 1ns/1ps
module rps_board
#(
  parameter int RISE_1V5 = 4
)(
  input  wire logic        clk_i,
  input  wire logic        power_on_i,
  input  wire logic        slow_ramp_i,
  input  wire logic [15:0] ramp_cyc_i,
  input  wire logic        clear_i,
  output logic             supply_above_1v5_o,
  output logic             supply_above_3v3_o,
  output logic             master_clear_pin_n_o
);
  logic [15:0] age = 16'h0000;

  // supply age in cycles; cutting power drops every level at once
  always @(negedge clk_i)
  begin
    if (!power_on_i)
      age <= 16'h0000;
    else if (age != 16'hFFFF)
      age <= age + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // comparators and the clear pin driven by the board
  assign supply_above_1v5_o = power_on_i && (age >= RISE_1V5);
  assign supply_above_3v3_o = power_on_i && (age >= ramp_cyc_i);
  // a slow ramp keeps clear low until the supply is good
  assign master_clear_pin_n_o =
    !(clear_i || (slow_ramp_i && !supply_above_3v3_o));
endmodule // rps_board

// ### bench/rps_supervisor_bench.sv
`timescale 1ns/1ps
module rps_supervisor_bench;
  typedef struct {
    logic [4:0] v;
    int         lo;
    int         hi;
  } rps_note_t;

  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic [2:0]  src = 3'h0;
  logic        power_on = 1'b0;
  logic        slow = 1'b0;
  logic [15:0] ramp = 16'h0014;
  logic        sleep_req = 1'b0;
  logic        wake = 1'b0;
  logic        start_det = 1'b0;
  logic [2:0]  lso_cnt = 3'h0;
  logic        low_speed_osc_clock = 1'b0;
  logic        s15, s33, master_clear_pin_n, rst_n, start, tmo, dsl, aen, core_en;
  logic [4:0]  last = 5'h01;
  logic [31:0] lfsr = 32'h955FC5A8;
  logic        mon_on = 1'b0;
  int          cyc = 0;
  int          t_last = 0;
  int          miscompares = 0;
  int          tests_run = 0;
  rps_note_t   notes[$];
  rps_note_t   n;
  wire [4:0]   outs = {rst_n, start, tmo, dsl, aen};

  rps_supervisor rps_supervisor_i (.clk_i(clk_i), .srst_i(srst_i),
    .master_clear_pin_n_i(master_clear_pin_n), .software_reset_request_i(src[1]),
    .watchdog_reset_request_i(src[2]), .supply_above_1v5_i(s15),
    .supply_above_3v3_i(s33), .low_speed_osc_clock_i(low_speed_osc_clock),
    .deep_sleep_request_i(sleep_req), .host_wake_interrupt_i(wake),
    .host_start_detect_i(start_det), .combined_reset_n_o(rst_n),
    .system_start_o(start), .powerup_timeout_o(tmo), .deep_sleep_o(dsl),
    .analog_regulator_en_o(aen), .core_regulator_en_o(core_en));

  rps_board rps_board_i (.clk_i(clk_i), .power_on_i(power_on),
    .slow_ramp_i(slow), .ramp_cyc_i(ramp), .clear_i(src[0]),
    .supply_above_1v5_o(s15), .supply_above_3v3_o(s33),
    .master_clear_pin_n_o(master_clear_pin_n));

  ////////////////////////////////////////////////////////////////////////////
  // clock and a low-speed oscillator eight cycles long, kept short for run time
  initial forever #50 clk_i = ~clk_i;
  always @(negedge clk_i)
  begin
    lso_cnt <= lso_cnt + 3'h1;
    low_speed_osc_clock <= lso_cnt[2];
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic tally_and_finish();
    if (miscompares == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask

  task automatic note(input logic [4:0] v, input int lo, input int hi);
    notes.push_back('{v, lo, hi});
  endtask

  // a missing output change ends the run instead of hanging it
  task automatic wait_empty(input int bound);
    for (int i = 0; i < bound && notes.size() != 0; i++)
      @(negedge clk_i);
    if (notes.size() != 0)
    begin
      miscompares++;
      tally_and_finish();
    end
  endtask

  task automatic run_after(input int k);
    note(5'h19, t_last + 8 * k - 8, t_last + 8 * k + 12);
    wait_empty(1000);
  endtask

  task automatic power_up(input logic s, input int r);
    int t0;
    int h;
    @(negedge clk_i);
    slow <= s;
    ramp <= r[15:0];
    power_on <= 1'b1;
    t0 = cyc;
    h = s ? r : 4;
    note(5'h15, t0 + h + 1998, t0 + h + 2006);
    wait_empty(5000);
    h = (t0 + r > t_last + 280) ? t0 + r : t_last + 280;
    note(5'h19, h, h + 20);
    wait_empty(3000);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // each output change takes the oldest note; a change with none is wrong
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (mon_on)
    begin
      chk(core_en, 1'b1);
      if (outs !== last)
      begin
        if (notes.size() == 0)
          chk(outs, last);
        else
        begin
          n = notes.pop_front();
          chk(outs, n.v);
          chk(cyc >= n.lo && cyc <= n.hi, 1'b1);
        end
        last <= outs;
        t_last <= cyc;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence: power-up, every source, sleep and wakes, slow and late supply
  initial
  begin
    int t;
    int len;
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
    srst_i <= 1'b0;
    mon_on <= 1'b1;
    power_up(1'b0, 20);
    for (int k = 0; k < 3; k++)
    begin
      lfsr = lfsr_next(lfsr);
      len = 1 + int'(lfsr[1:0]);
      @(negedge clk_i);
      src[k] <= 1'b1;
      t = cyc;
      note(5'h09, t, t);
      note(5'h01, t + 1, t + 1);
      repeat (len) @(negedge clk_i);
      src <= 3'h0;
      note(5'h15, t + len + 1998, t + len + 2006);
      wait_empty(3000);
      run_after(36);
    end
    for (int k = 0; k < 3; k++)
    begin
      @(negedge clk_i);
      sleep_req <= 1'b1;
      note(5'h12, cyc + 1, cyc + 1);
      @(negedge clk_i);
      sleep_req <= 1'b0;
      src[2] <= 1'b1;
      repeat (3) @(negedge clk_i);
      src[2] <= 1'b0;
      repeat (3) @(negedge clk_i);
      t = cyc;
      if (k == 0)
        wake <= 1'b1;
      else if (k == 1)
        start_det <= 1'b1;
      else
        src[0] <= 1'b1;
      if (k < 2)
        note(5'h15, t + 1, t + 1);
      else
      begin
        note(5'h02, t, t);
        note(5'h01, t + 1, t + 1);
        note(5'h15, t + 1999, t + 2006);
      end
      @(negedge clk_i);
      wake <= 1'b0;
      start_det <= 1'b0;
      src <= 3'h0;
      wait_empty(3000);
      run_after(k < 2 ? 10 : 36);
    end
    for (int k = 0; k < 2; k++)
    begin
      @(negedge clk_i);
      power_on <= 1'b0;
      slow <= 1'b0;
      note(5'h01, cyc + 1, cyc + 1);
      wait_empty(10);
      power_up(k == 0, k == 0 ? 2500 : 2600);
    end
    tally_and_finish();
  end
endmodule // rps_supervisor_bench
